// File: pkg/brcr_pkg.sv
// Constants and types of the bridge clock-run and retry-match block
package brcr_pkg;

    localparam int BRCR_ADDR_W = 8;
    localparam logic [7:0] BRCR_CRUN_OFS = 8'h6c;
    localparam logic [7:0] BRCR_POPT_OFS = 8'h74;

    // Clock-run register fields
    localparam int BRCR_CRUN_SSTAT_BIT = 24;
    localparam int BRCR_CRUN_SEN_BIT = 25;
    localparam int BRCR_CRUN_PKEEP_BIT = 26;
    localparam int BRCR_CRUN_PEN_BIT = 27;
    localparam int BRCR_CRUN_MODE_BIT = 28;
    localparam logic [31:0] BRCR_CRUN_WMASK = 32'h1e000000;
    localparam logic [31:0] BRCR_CRUN_RST = 32'h00000000;

    // Port option register fields
    localparam int BRCR_POPT_PRDA_BIT = 1;
    localparam int BRCR_POPT_SRDA_BIT = 3;
    localparam int BRCR_POPT_PLMA_BIT = 5;
    localparam int BRCR_POPT_SLMA_BIT = 6;
    localparam int BRCR_POPT_PMWI_BIT = 7;
    localparam int BRCR_POPT_SMWI_BIT = 8;
    localparam logic [31:0] BRCR_POPT_WMASK = 32'h000001ea;
    localparam logic [31:0] BRCR_POPT_RST = 32'h0000006a;

    // Bus commands
    localparam logic [3:0] BRCR_PLAIN_MEMORY_READ_CMD = 4'h6;
    localparam logic [3:0] BRCR_PLAIN_MEMORY_WRITE_CMD = 4'h7;
    localparam logic [3:0] BRCR_MEMORY_READ_MULTIPLE_CMD = 4'hc;
    localparam logic [3:0] BRCR_MEMORY_READ_LINE_CMD = 4'he;
    localparam logic [3:0] BRCR_WRITE_AND_INVALIDATE_CMD = 4'hf;

    // AXI responses
    localparam logic [1:0] BRCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] BRCR_RESP_DECERR = 2'h3;

    // Timing, in ns, and derived cycle counts
    localparam int BRCR_CLK_NS = 40;
    localparam int BRCR_HALT_NS = 640;
    localparam int BRCR_GRACE_NS = 1280;
    localparam int BRCR_PHOLD_NS = 640;
    localparam logic [7:0] BRCR_HALT_CYC = 8'((BRCR_HALT_NS + BRCR_CLK_NS - 1) / BRCR_CLK_NS);
    localparam logic [7:0] BRCR_GRACE_CYC = 8'((BRCR_GRACE_NS + BRCR_CLK_NS - 1) / BRCR_CLK_NS);
    localparam logic [7:0] BRCR_PHOLD_CYC = 8'((BRCR_PHOLD_NS + BRCR_CLK_NS - 1) / BRCR_CLK_NS);
    localparam logic [7:0] BRCR_SYNC_LAG = 8'h03;

    typedef enum logic [0:0] {BRCR_WR_COLLECT = 1'b0, BRCR_WR_RESP = 1'b1} brcr_wr_e;
    typedef enum logic [0:0] {BRCR_RD_IDLE = 1'b0, BRCR_RD_RESP = 1'b1} brcr_rd_e;
    typedef enum logic [1:0] {BRCR_SC_RUN = 2'b00, BRCR_SC_ASK = 2'b01, BRCR_SC_STOP = 2'b10} brcr_sc_e;
    typedef enum logic [0:0] {BRCR_PC_IDLE = 1'b0, BRCR_PC_HOLD = 1'b1} brcr_pc_e;

endpackage

// File: pkg/brcr_cmd_if.sv
// Command matching and conversion signals between top and matcher
`timescale 1ns/1ps
interface brcr_cmd_if;
    logic chk_valid;
    logic chk_side;
    logic [3:0] pend_cmd;
    logic [3:0] retry_cmd;
    logic chk_done;
    logic chk_hit;
    logic wr_valid;
    logic wr_side;
    logic [3:0] wr_cmd;
    logic fwd_valid;
    logic [3:0] fwd_cmd;
    logic [1:0] rd_alias;
    logic [1:0] lm_alias;
    logic [1:0] mwi_keep;

    modport ctl (
        output chk_valid, chk_side, pend_cmd, retry_cmd, wr_valid, wr_side, wr_cmd,
        output rd_alias, lm_alias, mwi_keep,
        input chk_done, chk_hit, fwd_valid, fwd_cmd
    );
    modport mat (
        input chk_valid, chk_side, pend_cmd, retry_cmd, wr_valid, wr_side, wr_cmd,
        input rd_alias, lm_alias, mwi_keep,
        output chk_done, chk_hit, fwd_valid, fwd_cmd
    );
endinterface

// File: logic/brcr_match.sv
// Retry command matcher and write-and-invalidate converter
`timescale 1ns/1ps
module brcr_match
    import brcr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    brcr_cmd_if.mat m // Command group
);

    // Line or multiple read
    function automatic logic is_lm(input logic [3:0] cmd);
        is_lm = (cmd == BRCR_MEMORY_READ_LINE_CMD) || (cmd == BRCR_MEMORY_READ_MULTIPLE_CMD);
    endfunction

    logic exact;
    logic rd_al;
    logic lm_al;
    logic hit;
    logic [3:0] conv;
    logic chk_done_q;
    logic chk_hit_q;
    logic fwd_valid_q;
    logic [3:0] fwd_cmd_q;

    // Match decode; the alias bit of the initiator's side decides
    assign exact = m.pend_cmd == m.retry_cmd;
    assign rd_al = m.rd_alias[m.chk_side] && (m.pend_cmd == BRCR_PLAIN_MEMORY_READ_CMD)
                   && is_lm(m.retry_cmd);
    assign lm_al = m.lm_alias[m.chk_side] && is_lm(m.pend_cmd) && is_lm(m.retry_cmd);
    assign hit = exact || rd_al || lm_al;

    // Conversion uses the accepting side's disable bit
    assign conv = ((m.wr_cmd == BRCR_WRITE_AND_INVALIDATE_CMD) && !m.mwi_keep[m.wr_side])
                  ? BRCR_PLAIN_MEMORY_WRITE_CMD : m.wr_cmd;

    // One cycle of latency for both answers
    always_ff @(posedge clk) begin
        if (rst) begin
            chk_done_q <= 1'b0;
            chk_hit_q <= 1'b0;
            fwd_valid_q <= 1'b0;
            fwd_cmd_q <= 4'h0;
        end else begin
            chk_done_q <= m.chk_valid;
            chk_hit_q <= m.chk_valid && hit;
            fwd_valid_q <= m.wr_valid;
            fwd_cmd_q <= m.wr_valid ? conv : fwd_cmd_q;
        end
    end

    assign m.chk_done = chk_done_q;
    assign m.chk_hit = chk_hit_q;
    assign m.fwd_valid = fwd_valid_q;
    assign m.fwd_cmd = fwd_cmd_q;

endmodule

// File: logic/brcr_top.sv
// Bridge clock-run control and retry match options with AXI4-Lite registers
`timescale 1ns/1ps
module brcr_top
    import brcr_pkg::*;
(
    input wire logic CLK_SYS, // 25 MHz system clock
    input wire logic RST, // Synchronous reset, high
    input wire logic [BRCR_ADDR_W-1:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [BRCR_ADDR_W-1:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic S_CLK, // Secondary bus clock, sampled
    input wire logic P_CLOCK_RUN_CONTROL_N_I, // Primary clock-run line level
    output logic P_CLOCK_RUN_CONTROL_N_O, // Primary clock-run drive value
    output logic P_CLOCK_RUN_CONTROL_N_OE_N, // Primary clock-run enable, low drives
    input wire logic S_CLOCK_RUN_CONTROL_N_I, // Secondary clock-run line level
    output logic S_CLOCK_RUN_CONTROL_N_O, // Secondary clock-run drive value
    output logic S_CLOCK_RUN_CONTROL_N_OE_N, // Secondary clock-run enable, low drives
    input wire logic S_BUS_IDLE, // Secondary bus idle, pin
    input wire logic P_REQ_PEND, // Primary request pending, pin
    output logic S_CLK_STOP, // Request to halt secondary clock
    input wire logic MT_VALID, // Retry compare request
    input wire logic MT_SIDE, // 0 primary, 1 secondary initiator
    input wire logic [3:0] MT_PEND_CMD, // Pending command
    input wire logic [3:0] MT_RETRY_CMD, // Retried command
    output logic MT_DONE, // Compare answer strobe
    output logic MT_HIT, // Retry matches pending
    input wire logic WR_VALID, // Accepted write strobe
    input wire logic WR_SIDE, // 0 primary, 1 secondary accepting side
    input wire logic [3:0] WR_CMD, // Accepted write command
    output logic WR_FWD_VALID, // Forwarded command strobe
    output logic [3:0] WR_FWD_CMD // Command for destination side
);

    // Byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] r;
        r = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = {8{strb[i]}};
        end
        strb_mask = r;
    endfunction

    // Word address compare, low two address bits ignored
    function automatic logic word_is(input logic [BRCR_ADDR_W-1:0] a, input logic [7:0] ofs);
        word_is = a[BRCR_ADDR_W-1:2] == ofs[7:2];
    endfunction

    brcr_cmd_if cmd_bus ();

    // Pin inputs: index 0 clock, 1 primary line, 2 secondary line, 3 idle, 4 pending
    logic [4:0] pin_in;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic s_clk_prev_q;
    logic s_clk_edge;
    logic p_line_hi;
    logic s_line_hi;
    logic s_idle;
    logic p_pend;

    // Register file
    logic [31:0] crun_q;
    logic [31:0] crun_d;
    logic [31:0] popt_q;
    logic [31:0] popt_d;
    logic sec_en;
    logic p_en;
    logic p_keep;
    logic run_mode;

    // Write channel
    brcr_wr_e wr_st_q;
    brcr_wr_e wr_st_d;
    logic aw_have_q;
    logic aw_have_d;
    logic w_have_q;
    logic w_have_d;
    logic [BRCR_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic commit;
    logic wr_crun;
    logic wr_popt;
    logic [31:0] wmask;

    // Read channel
    brcr_rd_e rd_st_q;
    brcr_rd_e rd_st_d;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_fire;
    logic r_fire;
    logic rd_crun;
    logic rd_popt;
    logic [31:0] rd_word;

    // Clock-run control
    brcr_sc_e sc_st_q;
    brcr_sc_e sc_st_d;
    brcr_pc_e pc_st_q;
    brcr_pc_e pc_st_d;
    logic [7:0] grace_cnt_q;
    logic [7:0] grace_cnt_d;
    logic [7:0] halt_cnt_q;
    logic [7:0] halt_cnt_d;
    logic [7:0] phold_cnt_q;
    logic [7:0] phold_cnt_d;
    logic sec_stopped_q;
    logic sec_stopped_d;
    logic p_oe_n_q;
    logic s_oe_n_q;
    logic s_stop_q;
    logic p_stop_req;
    logic sec_want;
    logic p_object;

    // Two-stage synchroniser for every pin input
    assign pin_in = {P_REQ_PEND, S_BUS_IDLE, S_CLOCK_RUN_CONTROL_N_I, P_CLOCK_RUN_CONTROL_N_I, S_CLK};
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            s_clk_prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            s_clk_prev_q <= sync2_q[0];
        end
    end

    // Synchronised levels; either clock edge counts as activity
    assign s_clk_edge = sync2_q[0] != s_clk_prev_q;
    assign p_line_hi = sync2_q[1];
    assign s_line_hi = sync2_q[2];
    assign s_idle = sync2_q[3];
    assign p_pend = sync2_q[4];

    // Control bits decoded from the registers
    assign sec_en = crun_q[BRCR_CRUN_SEN_BIT];
    assign p_keep = crun_q[BRCR_CRUN_PKEEP_BIT];
    assign p_en = crun_q[BRCR_CRUN_PEN_BIT];
    assign run_mode = crun_q[BRCR_CRUN_MODE_BIT];

    // Write channel handshakes; address and data taken in either order
    assign aw_fire = S_AXI_AWVALID && awready_q;
    assign w_fire = S_AXI_WVALID && wready_q;
    assign b_fire = bvalid_q && S_AXI_BREADY;
    assign commit = (wr_st_q == BRCR_WR_COLLECT) && aw_have_q && w_have_q;
    assign aw_have_d = commit ? 1'b0 : (aw_have_q || aw_fire);
    assign w_have_d = commit ? 1'b0 : (w_have_q || w_fire);
    assign wr_st_d = commit ? BRCR_WR_RESP : (b_fire ? BRCR_WR_COLLECT : wr_st_q);

    // Register write decode; only writable bits change, reserved stay zero
    assign wr_crun = commit && word_is(awaddr_q, BRCR_CRUN_OFS);
    assign wr_popt = commit && word_is(awaddr_q, BRCR_POPT_OFS);
    assign wmask = strb_mask(wstrb_q);
    assign crun_d = wr_crun ? ((crun_q & ~BRCR_CRUN_WMASK) | (wdata_q & wmask & BRCR_CRUN_WMASK))
                            : crun_q;
    assign popt_d = wr_popt ? ((popt_q & ~BRCR_POPT_WMASK) | (wdata_q & wmask & BRCR_POPT_WMASK))
                            : popt_q;

    // Write channel state and registers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wr_st_q <= BRCR_WR_COLLECT;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= BRCR_RESP_OKAY;
            crun_q <= BRCR_CRUN_RST;
            popt_q <= BRCR_POPT_RST;
        end else begin
            wr_st_q <= wr_st_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= aw_fire ? S_AXI_AWADDR : awaddr_q;
            wdata_q <= w_fire ? S_AXI_WDATA : wdata_q;
            wstrb_q <= w_fire ? S_AXI_WSTRB : wstrb_q;
            awready_q <= (wr_st_d == BRCR_WR_COLLECT) && !aw_have_d;
            wready_q <= (wr_st_d == BRCR_WR_COLLECT) && !w_have_d;
            bvalid_q <= commit || (bvalid_q && !S_AXI_BREADY);
            bresp_q <= commit ? ((wr_crun || wr_popt) ? BRCR_RESP_OKAY : BRCR_RESP_DECERR) : bresp_q;
            crun_q <= crun_d;
            popt_q <= popt_d;
        end
    end

    // Read decode; status bit is live state, not stored with the control bits
    assign ar_fire = S_AXI_ARVALID && arready_q;
    assign r_fire = rvalid_q && S_AXI_RREADY;
    assign rd_st_d = ar_fire ? BRCR_RD_RESP : (r_fire ? BRCR_RD_IDLE : rd_st_q);
    assign rd_crun = word_is(S_AXI_ARADDR, BRCR_CRUN_OFS);
    assign rd_popt = word_is(S_AXI_ARADDR, BRCR_POPT_OFS);
    assign rd_word = rd_crun ? {crun_q[31:BRCR_CRUN_SSTAT_BIT+1], sec_stopped_q,
                                crun_q[BRCR_CRUN_SSTAT_BIT-1:0]}
                   : (rd_popt ? popt_q : 32'h00000000);

    // Read channel; data is captured at the address handshake
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rd_st_q <= BRCR_RD_IDLE;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= BRCR_RESP_OKAY;
        end else begin
            rd_st_q <= rd_st_d;
            arready_q <= rd_st_d == BRCR_RD_IDLE;
            rvalid_q <= rd_st_d == BRCR_RD_RESP;
            rdata_q <= ar_fire ? rd_word : rdata_q;
            rresp_q <= ar_fire ? ((rd_crun || rd_popt) ? BRCR_RESP_OKAY : BRCR_RESP_DECERR) : rresp_q;
        end
    end

    // Stop request from the primary side ignores the line while we pull it
    assign p_stop_req = p_line_hi && (pc_st_q == BRCR_PC_IDLE);
    assign sec_want = sec_en && (run_mode ? (s_idle && !p_pend) : p_stop_req);

    // Secondary stop sequence: release line, wait grace with no objection, then halt
    always_comb begin
        sc_st_d = sc_st_q;
        unique case (sc_st_q)
            BRCR_SC_RUN: begin
                if (sec_want) begin
                    sc_st_d = BRCR_SC_ASK;
                end
            end
            BRCR_SC_ASK: begin
                // Synchroniser lag shows our own drive for a few cycles
                if (!sec_want || (!s_line_hi && grace_cnt_q >= BRCR_SYNC_LAG)) begin
                    sc_st_d = BRCR_SC_RUN;
                end else if (grace_cnt_q == BRCR_GRACE_CYC - 8'h01) begin
                    sc_st_d = BRCR_SC_STOP;
                end
            end
            BRCR_SC_STOP: begin
                if (!sec_want || !s_line_hi) begin
                    sc_st_d = BRCR_SC_RUN;
                end
            end
            default: begin
                sc_st_d = BRCR_SC_RUN;
            end
        endcase
    end

    assign grace_cnt_d = ((sc_st_q == BRCR_SC_ASK) && (sc_st_d == BRCR_SC_ASK)) ? grace_cnt_q + 8'h01 : 8'h00;

    // Halt detection: no clock edge for the halt window while stop is asked
    assign halt_cnt_d = (s_clk_edge || (sc_st_q != BRCR_SC_STOP)) ? 8'h00
                      : ((halt_cnt_q == BRCR_HALT_CYC) ? halt_cnt_q : halt_cnt_q + 8'h01);
    assign sec_stopped_d = s_clk_edge ? 1'b0 : (sec_stopped_q || (halt_cnt_q == BRCR_HALT_CYC));

    // Primary objection: hold the line low to keep the primary clock
    assign p_object = p_en && p_line_hi && (p_keep || !sec_stopped_q);
    assign pc_st_d = (pc_st_q == BRCR_PC_IDLE) ? (p_object ? BRCR_PC_HOLD : BRCR_PC_IDLE)
                   : ((phold_cnt_q == BRCR_PHOLD_CYC - 8'h01) ? BRCR_PC_IDLE : BRCR_PC_HOLD);
    assign phold_cnt_d = ((pc_st_q == BRCR_PC_HOLD) && (pc_st_d == BRCR_PC_HOLD)) ? phold_cnt_q + 8'h01 : 8'h00;

    // Clock-run state, counters and pin drivers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sc_st_q <= BRCR_SC_RUN;
            pc_st_q <= BRCR_PC_IDLE;
            grace_cnt_q <= 8'h00;
            halt_cnt_q <= 8'h00;
            phold_cnt_q <= 8'h00;
            sec_stopped_q <= 1'b0;
            p_oe_n_q <= 1'b1;
            s_oe_n_q <= 1'b0;
            s_stop_q <= 1'b0;
        end else begin
            sc_st_q <= sc_st_d;
            pc_st_q <= pc_st_d;
            grace_cnt_q <= grace_cnt_d;
            halt_cnt_q <= halt_cnt_d;
            phold_cnt_q <= phold_cnt_d;
            sec_stopped_q <= sec_stopped_d;
            p_oe_n_q <= pc_st_d != BRCR_PC_HOLD;
            s_oe_n_q <= sc_st_d != BRCR_SC_RUN;
            s_stop_q <= sc_st_d == BRCR_SC_STOP;
        end
    end

    // Matcher options per side, index 0 primary
    assign cmd_bus.rd_alias = {popt_q[BRCR_POPT_SRDA_BIT], popt_q[BRCR_POPT_PRDA_BIT]};
    assign cmd_bus.lm_alias = {popt_q[BRCR_POPT_SLMA_BIT], popt_q[BRCR_POPT_PLMA_BIT]};
    assign cmd_bus.mwi_keep = {popt_q[BRCR_POPT_SMWI_BIT], popt_q[BRCR_POPT_PMWI_BIT]};
    assign cmd_bus.chk_valid = MT_VALID;
    assign cmd_bus.chk_side = MT_SIDE;
    assign cmd_bus.pend_cmd = MT_PEND_CMD;
    assign cmd_bus.retry_cmd = MT_RETRY_CMD;
    assign cmd_bus.wr_valid = WR_VALID;
    assign cmd_bus.wr_side = WR_SIDE;
    assign cmd_bus.wr_cmd = WR_CMD;

    brcr_match u_match (
        .clk (CLK_SYS),
        .rst (RST),
        .m (cmd_bus.mat)
    );

    // Outputs from flops, drive values tied low; open-drain lines only ever pull low
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign P_CLOCK_RUN_CONTROL_N_O = 1'b0;
    assign P_CLOCK_RUN_CONTROL_N_OE_N = p_oe_n_q;
    assign S_CLOCK_RUN_CONTROL_N_O = 1'b0;
    assign S_CLOCK_RUN_CONTROL_N_OE_N = s_oe_n_q;
    assign S_CLK_STOP = s_stop_q;
    assign MT_DONE = cmd_bus.chk_done;
    assign MT_HIT = cmd_bus.chk_hit;
    assign WR_FWD_VALID = cmd_bus.fwd_valid;
    assign WR_FWD_CMD = cmd_bus.fwd_cmd;

endmodule

// File: bench/brcr_far_model.sv
// Far side: secondary clock source and clock-run line pull-ups
`timescale 1ns/1ps
module brcr_far_model (
    input wire logic clk_stop, // Halt request
    input wire logic p_ask_stop, // Primary host lets clock stop
    input wire logic p_oe_n, // Bridge drive, primary line
    input wire logic s_oe_n, // Bridge drive, secondary line
    output logic s_clk, // Secondary clock, 320 ns
    output logic p_line, // Primary line level
    output logic s_line // Secondary line level
);
    // Pulled-up lines; any driver pulls them low
    assign p_line = p_ask_stop & p_oe_n;
    assign s_line = s_oe_n;
    // Odd start offset keeps the two clocks out of phase; halts while asked
    initial begin
        s_clk = 1'b0;
        #7;
        forever #160 if (!clk_stop) s_clk = ~s_clk;
    end
endmodule

// File: bench/brcr_checker.sv
// Port assertions for the clock-run and retry-match block
`timescale 1ns/1ps
module brcr_checker (
    input wire logic CLK_SYS, // Clock
    input wire logic RST, // Reset
    input wire logic S_CLOCK_RUN_CONTROL_N_OE_N, // Line release
    input wire logic S_CLK_STOP, // Halt request
    input wire logic MT_VALID, // Compare request
    input wire logic [3:0] MT_PEND_CMD, // Pending
    input wire logic [3:0] MT_RETRY_CMD, // Retried
    input wire logic MT_DONE, // Answer
    input wire logic MT_HIT, // Match
    input wire logic WR_VALID, // Write in
    input wire logic [3:0] WR_CMD, // Write command
    input wire logic WR_FWD_VALID, // Write out
    input wire logic [3:0] WR_FWD_CMD // Forwarded command
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    // Matcher and converter answer one cycle after each request
    a_match_answer: assert property (MT_VALID |=> MT_DONE) else $error("no answer");
    a_exact_hit: assert property (MT_VALID && MT_PEND_CMD == MT_RETRY_CMD |=> MT_HIT) else $error("miss");
    a_hit_strobe: assert property (MT_HIT |-> MT_DONE) else $error("stray hit");
    a_fwd_strobe: assert property (WR_VALID |=> WR_FWD_VALID) else $error("no forward");
    a_fwd_plain: assert property (WR_VALID && WR_CMD != 4'hf |=> WR_FWD_CMD == $past(WR_CMD)) else $error("bad cmd");
    a_fwd_mwi: assert property (WR_VALID && WR_CMD == 4'hf |=> WR_FWD_CMD inside {4'h7, 4'hf}) else $error("bad mwi");
    // A halt is only asked with the line released, and never at once
    a_stop_released: assert property (S_CLK_STOP |-> S_CLOCK_RUN_CONTROL_N_OE_N) else $error("stop held");
    a_stop_grace: assert property ($rose(S_CLOCK_RUN_CONTROL_N_OE_N) |-> (!S_CLK_STOP) [*8]) else $error("early stop");
    c_hit: cover property (MT_DONE && MT_HIT);
    c_stop: cover property ($rose(S_CLK_STOP));
    c_conv: cover property (WR_FWD_VALID && WR_FWD_CMD == 4'h7);
endmodule
bind brcr_top brcr_checker brcr_checker_inst (.CLK_SYS(CLK_SYS), .RST(RST), .S_CLOCK_RUN_CONTROL_N_OE_N(S_CLOCK_RUN_CONTROL_N_OE_N),
    .S_CLK_STOP(S_CLK_STOP), .MT_VALID(MT_VALID), .MT_PEND_CMD(MT_PEND_CMD), .MT_RETRY_CMD(MT_RETRY_CMD),
    .MT_DONE(MT_DONE), .MT_HIT(MT_HIT), .WR_VALID(WR_VALID), .WR_CMD(WR_CMD), .WR_FWD_VALID(WR_FWD_VALID),
    .WR_FWD_CMD(WR_FWD_CMD));

// File: bench/brcr_top_tb.sv
// Bench for the clock-run and retry-match block
`timescale 1ns/1ps
module brcr_top_tb;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic sidle = 1'b0, ppend = 1'b0, mtv = 1'b0, mts = 1'b0, wrv = 1'b0, wrs = 1'b0, pask = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] mtp = 4'h0, mtr = 4'h0, wrc = 4'h0;
    logic awr, wrd, bv, arr, rv, poe, soe, stop, mtd, mth, wfv, sclk, pl, sl;
    logic [1:0] br, rr;
    logic [31:0] rdat;
    logic [3:0] wfc;
    int bad_count = 0, checks = 0;
    always #20 clk = ~clk;
    brcr_top brcr_top_inst (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_CLK(sclk),
        .P_CLOCK_RUN_CONTROL_N_I(pl), .P_CLOCK_RUN_CONTROL_N_O(), .P_CLOCK_RUN_CONTROL_N_OE_N(poe), .S_CLOCK_RUN_CONTROL_N_I(sl), .S_CLOCK_RUN_CONTROL_N_O(),
        .S_CLOCK_RUN_CONTROL_N_OE_N(soe), .S_BUS_IDLE(sidle), .P_REQ_PEND(ppend), .S_CLK_STOP(stop), .MT_VALID(mtv),
        .MT_SIDE(mts), .MT_PEND_CMD(mtp), .MT_RETRY_CMD(mtr), .MT_DONE(mtd), .MT_HIT(mth), .WR_VALID(wrv),
        .WR_SIDE(wrs), .WR_CMD(wrc), .WR_FWD_VALID(wfv), .WR_FWD_CMD(wfc));
    brcr_far_model brcr_far_model_inst (.clk_stop(stop), .p_ask_stop(pask), .p_oe_n(poe), .s_oe_n(soe),
        .s_clk(sclk), .p_line(pl), .s_line(sl));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Register write; bounded wait on the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 60);
        bry <= 1'b0;
        check(br, er);
        if (bv !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // Register read; data taken at the handshake edge
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 60);
        rry <= 1'b0;
        check(rdat, ed);
        check(rr, er);
        if (rv !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // Looks for a level on the halt request or the primary drive for n cycles
    task automatic watch(input bit sel, input logic lvl, input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if ((sel ? poe : stop) === lvl) seen = 1'b1;
        end
        check(seen, exp);
        if (exp && !seen) tally_and_finish();
    endtask
    task automatic mt(input logic s, input logic [3:0] p, input logic [3:0] r, input logic e);
        mts <= s;
        mtp <= p;
        mtr <= r;
        mtv <= 1'b1;
        @(posedge clk);
        mtv <= 1'b0;
        @(posedge clk);
        check({mtd, mth}, {1'b1, e});
    endtask
    task automatic cv(input logic s, input logic [3:0] c, input logic [3:0] e);
        wrs <= s;
        wrc <= c;
        wrv <= 1'b1;
        @(posedge clk);
        wrv <= 1'b0;
        @(posedge clk);
        check({wfv, wfc}, {1'b1, e});
    endtask
    // Reset values, read-only bits, unmapped place
    task automatic regs();
        rd(8'h6c, 32'h0, 2'h0);
        rd(8'h74, 32'h6a, 2'h0);
        wr(8'h6c, 32'hffffffff, 2'h0);
        rd(8'h6c, 32'h1e000000, 2'h0);
        wr(8'h74, 32'hffffffff, 2'h0);
        rd(8'h74, 32'h1ea, 2'h0);
        wr(8'h10, 32'h5, 2'h3);
        rd(8'h10, 32'h0, 2'h3);
        wr(8'h6c, 32'h0, 2'h0);
    endtask
    // Retry matching with aliases on, off and per side
    task automatic match();
        mt(1'b0, 4'h6, 4'he, 1'b1);
        mt(1'b1, 4'hc, 4'he, 1'b1);
        mt(1'b0, 4'he, 4'h6, 1'b0);
        wr(8'h74, 32'h0, 2'h0);
        mt(1'b1, 4'h6, 4'hc, 1'b0);
        mt(1'b0, 4'he, 4'hc, 1'b0);
        mt(1'b1, 4'he, 4'he, 1'b1);
        wr(8'h74, 32'h42, 2'h0);
        mt(1'b0, 4'h6, 4'hc, 1'b1);
        mt(1'b1, 4'h6, 4'hc, 1'b0);
        mt(1'b1, 4'hc, 4'he, 1'b1);
        mt(1'b0, 4'hc, 4'he, 1'b0);
    endtask
    // Write-and-invalidate conversion per accepting side
    task automatic conv();
        wr(8'h74, 32'h100, 2'h0);
        cv(1'b0, 4'hf, 4'h7);
        cv(1'b1, 4'hf, 4'hf);
        wr(8'h74, 32'h80, 2'h0);
        cv(1'b0, 4'hf, 4'hf);
        cv(1'b1, 4'hf, 4'h7);
        cv(1'b0, 4'h7, 4'h7);
    endtask
    // Secondary stop: self-timed, status, restart, refusals, request mode
    task automatic sec_run();
        wr(8'h6c, 32'h12000000, 2'h0);
        sidle <= 1'b1;
        watch(1'b0, 1'b1, 80, 1'b1);
        rd(8'h6c, 32'h13000000, 2'h0);
        sidle <= 1'b0;
        watch(1'b0, 1'b0, 20, 1'b1);
        rd(8'h6c, 32'h12000000, 2'h0);
        ppend <= 1'b1;
        sidle <= 1'b1;
        watch(1'b0, 1'b1, 60, 1'b0);
        wr(8'h6c, 32'h10000000, 2'h0);
        ppend <= 1'b0;
        watch(1'b0, 1'b1, 60, 1'b0);
        wr(8'h6c, 32'h02000000, 2'h0);
        watch(1'b0, 1'b1, 60, 1'b0);
        pask <= 1'b1;
        watch(1'b0, 1'b1, 60, 1'b1);
        watch(1'b1, 1'b0, 30, 1'b0);
    endtask
    // Primary hold refused with secondary stopped, given when kept
    task automatic prim_run();
        wr(8'h6c, 32'h0b000000, 2'h0);
        watch(1'b1, 1'b0, 30, 1'b0);
        wr(8'h6c, 32'h0f000000, 2'h0);
        watch(1'b1, 1'b0, 30, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regs();
        match();
        conv();
        sec_run();
        prim_run();
        tally_and_finish();
    end
endmodule
